// ===== hw/fault_recorder_consts.svh
// Constants of the fault capture recorder
`ifndef FAULT_RECORDER_CONSTS_SVH
`define FAULT_RECORDER_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL_OFF      8'h00
`define REG_PRE_OFF       8'h04
`define REG_POST_OFF      8'h08
`define REG_MAX_OFF       8'h0C
`define REG_STAT_OFF      8'h10
`define REG_IRQ_OFF       8'h14
`define REG_MASK_OFF      8'h18
`define REG_REC_OFF       8'h1C
`define REG_RATE_OFF      8'h20
`define REG_SIZE_OFF      8'h24
`define REG_RD_ADDR_OFF   8'h28
`define REG_RD_DATA_OFF   8'h2C
`define REG_CHAN_OFF      8'h30

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTRL_EN_BIT       0
`define CTRL_RATE_BIT     1

// ----------------------------------------------------------------
// Interrupt status fields
// ----------------------------------------------------------------
`define IRQ_DONE_BIT      0
`define IRQ_SETERR_BIT    1
`define IRQ_FULL_BIT      2
`define IRQ_START_BIT     3
`define IRQ_W             4

// ----------------------------------------------------------------
// Settings in milliseconds
// ----------------------------------------------------------------
`define PRE_MIN_MS        16'd100
`define PRE_MAX_MS        16'd1000
`define PRE_DEF_MS        16'd200
`define POST_DEF_MS       16'd200
`define MAX_MIN_MS        16'd500
`define MAX_MAX_MS        16'd10000
`define MAX_DEF_MS        16'd1000

// ----------------------------------------------------------------
// Channels, rates and storage
// ----------------------------------------------------------------
`define NUM_BIN           64
`define NUM_ANA           32
`define SPP_BASE          20
`define SPP_FAST          40
`define STORE_BYTES       12582912
`define ANA_KB_PER_S      7
`define BIN_KB_PER_S      2
`define KB_BYTES          1024
`define COMTRADE_FILES    3

`endif

// ===== hw/fault_recorder_pkg.sv
// Types of the fault capture recorder
package fault_recorder_pkg;

  // ----------------------------------------------------------------
  // Capture states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_ARMED  = 3'b001,
    ST_TRIG   = 3'b010,
    ST_POST   = 3'b011,
    ST_REARM  = 3'b100
  } cap_state_t;

  // ----------------------------------------------------------------
  // Sample from the front end
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [63:0]      bin;
    logic [32*16-1:0] ana;
  } sample_t;

  // ----------------------------------------------------------------
  // Export packet of one record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  kind;
    logic [31:0] start;
    logic [31:0] length;
  } export_t;

  typedef enum logic [1:0] {
    EXP_CFG = 2'b00,
    EXP_DAT = 2'b01,
    EXP_INF = 2'b10
  } export_kind_t;

endpackage : fault_recorder_pkg

// ===== hw/fault_capture_recorder.sv
// Triggered fault capture recorder with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "fault_recorder_consts.svh"

module fault_capture_recorder #(
  parameter int          SELECTABLE = 1,
  parameter int          DEPTH_LOG2 = 12,
  parameter int          NET_HZ     = 50
) (
  // Clock and reset
  input  wire logic                         CLK,
  input  wire logic                         RST_B,
  // Avalon-MM slave
  input  wire logic [7:0]                   AVS_ADDRESS,
  input  wire logic                         AVS_READ,
  input  wire logic                         AVS_WRITE,
  input  wire logic [31:0]                  AVS_WRITEDATA,
  output logic      [31:0]                  AVS_READDATA,
  output logic                              AVS_WAITREQUEST,
  // Front end
  input  wire logic                         SAMPLE_STB,
  input  wire fault_recorder_pkg::sample_t  SAMPLE,
  input  wire logic                         TRIGGER,
  // Record output and status
  output fault_recorder_pkg::export_t       EXPORT,
  output logic                              EXPORT_VALID,
  output logic                              WARNING,
  output logic                              IRQ
);
  import fault_recorder_pkg::*;

  localparam int DEPTH = 1 << DEPTH_LOG2;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] trig_sync_r;
  logic [1:0] stb_sync_r;
  logic       stb_last_r;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      trig_sync_r <= 2'b00;
      stb_sync_r  <= 2'b00;
      stb_last_r  <= 1'b0;
    end else begin
      trig_sync_r <= {trig_sync_r[0], TRIGGER};
      stb_sync_r  <= {stb_sync_r[0], SAMPLE_STB};
      stb_last_r  <= stb_sync_r[1];
    end
  end
  wire trig     = trig_sync_r[1];
  wire tick     = stb_sync_r[1] & ~stb_last_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0]           ctrl_r;
  logic [15:0]          pre_ms_r;
  logic [15:0]          post_ms_r;
  logic [15:0]          max_ms_r;
  logic [`IRQ_W-1:0]    irq_r;
  logic [`IRQ_W-1:0]    mask_r;
  logic [15:0]          rec_cnt_r;
  logic [DEPTH_LOG2-1:0] rd_addr_r;
  logic [31:0]          rd_data_r;
  logic                 rd_done_r;
  logic [31:0]          used_r;

  function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
    if (v[31:16] != 16'h0000 || v[15:0] > hi) return hi;
    if (v[15:0] < lo) return lo;
    return v[15:0];
  endfunction : clamp

  wire       wr        = AVS_WRITE & ~AVS_WAITREQUEST;
  wire       rd_req    = AVS_READ;
  wire       sel_ctrl  = AVS_ADDRESS == `REG_CTRL_OFF;
  wire       sel_pre   = AVS_ADDRESS == `REG_PRE_OFF;
  wire       sel_post  = AVS_ADDRESS == `REG_POST_OFF;
  wire       sel_max   = AVS_ADDRESS == `REG_MAX_OFF;
  wire       sel_irq   = AVS_ADDRESS == `REG_IRQ_OFF;
  wire       sel_mask  = AVS_ADDRESS == `REG_MASK_OFF;
  wire       sel_raddr = AVS_ADDRESS == `REG_RD_ADDR_OFF;
  wire       wr_ctrl   = wr & sel_ctrl;
  wire       wr_pre    = wr & sel_pre;
  wire       wr_post   = wr & sel_post;
  wire       wr_max    = wr & sel_max;
  wire       wr_irq    = wr & sel_irq;
  wire       wr_mask   = wr & sel_mask;
  wire       wr_raddr  = wr & sel_raddr;
  wire       enable    = ctrl_r[`CTRL_EN_BIT];
  wire       fast      = (SELECTABLE != 0) & ctrl_r[`CTRL_RATE_BIT];
  wire [4:0] spp       = fast ? 5'(`SPP_FAST / 2) : 5'(`SPP_BASE / 2);

  // Samples per millisecond scaled by 1000: spp*NET_HZ*2 samples per second
  wire [31:0] rate_sps = 32'(spp) * 32'(NET_HZ) * 32'd2;
  function automatic logic [31:0] ms2smp(input logic [15:0] ms, input logic [31:0] sps);
    logic [47:0] p;
    p = 48'(ms) * 48'(sps);
    return 32'(p / 48'd1000);
  endfunction : ms2smp
  wire [31:0] pre_smp  = ms2smp(pre_ms_r, rate_sps);
  wire [31:0] post_smp = ms2smp(post_ms_r, rate_sps);
  wire [31:0] max_smp  = ms2smp(max_ms_r, rate_sps);
  wire        set_err  = (17'(pre_ms_r) + 17'(post_ms_r)) > 17'(max_ms_r);

  // ----------------------------------------------------------------
  // History memory and capture state
  // ----------------------------------------------------------------
  sample_t               mem [DEPTH];
  cap_state_t            st_r;
  cap_state_t            st_nxt;
  logic [DEPTH_LOG2-1:0] wp_r;
  logic [31:0]           fill_r;
  logic [31:0]           cnt_r;
  logic [31:0]           rec_start_r;
  logic [31:0]           rec_len_r;
  logic [31:0]           wtotal_r;
  logic [1:0]            exp_idx_r;

  // ----------------------------------------------------------------
  // Storage budget and start condition
  // ----------------------------------------------------------------
  localparam int BYTES_PER_S = (`NUM_ANA * `ANA_KB_PER_S + `NUM_BIN * `BIN_KB_PER_S) * `KB_BYTES;
  wire [17:0] rec_ms    = 18'(max_ms_r) + 18'(pre_ms_r) + 18'(post_ms_r);
  wire [47:0] rec_prod  = 48'(BYTES_PER_S) * 48'(rec_ms);
  wire [47:0] rec_quot  = rec_prod / 48'd1000;
  wire [31:0] rec_bytes = rec_quot[31:0];
  wire [32:0] used_sum  = {1'b0, used_r} + {1'b0, rec_bytes};
  wire        room      = used_sum <= 33'(`STORE_BYTES);
  wire        arm_ok    = fill_r >= pre_smp;
  wire        go        = enable & trig & arm_ok & room;

  // ----------------------------------------------------------------
  // Capture state machine
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_OFF:   if (enable) st_nxt = ST_REARM;
      ST_ARMED: if (!enable) st_nxt = ST_OFF;
                else if (go) st_nxt = ST_TRIG;
      ST_TRIG:  if (tick && (!trig || cnt_r + 32'd1 >= max_smp)) st_nxt = ST_POST;
      ST_POST:  if (tick && cnt_r + 32'd1 >= post_smp) st_nxt = ST_REARM;
      ST_REARM: if (!enable) st_nxt = ST_OFF;
                else if (!trig) st_nxt = ST_ARMED;
      default:  st_nxt = ST_OFF;
    endcase
  end

  wire rec_done = (st_r == ST_POST) & (st_nxt == ST_REARM);

  always_ff @(posedge CLK) begin
    if (tick && st_r != ST_OFF) mem[wp_r] <= SAMPLE;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r        <= ST_OFF;
      wp_r        <= '0;
      fill_r      <= 32'h0000_0000;
      cnt_r       <= 32'h0000_0000;
      rec_start_r <= 32'h0000_0000;
      rec_len_r   <= 32'h0000_0000;
      wtotal_r    <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      if (st_r == ST_OFF) fill_r <= 32'h0000_0000;
      else if (tick && st_r != ST_OFF) begin
        wp_r     <= wp_r + 1'b1;
        wtotal_r <= wtotal_r + 32'd1;
        if (fill_r < 32'(DEPTH)) fill_r <= fill_r + 32'd1;
      end
      if (st_nxt != st_r) cnt_r <= 32'h0000_0000;
      else if (tick) cnt_r <= cnt_r + 32'd1;
      if (st_r == ST_ARMED && st_nxt == ST_TRIG) begin
        rec_start_r <= wtotal_r - pre_smp;
        rec_len_r   <= pre_smp;
      end else if (tick && (st_r == ST_TRIG || st_r == ST_POST)) begin
        rec_len_r   <= rec_len_r + 32'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Export of the three record files
  // ----------------------------------------------------------------
  wire [1:0] exp_kind = 2'(`COMTRADE_FILES) - exp_idx_r;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      exp_idx_r    <= 2'b00;
      EXPORT_VALID <= 1'b0;
      EXPORT       <= '0;
    end else begin
      EXPORT_VALID <= 1'b0;
      if (rec_done) exp_idx_r <= 2'(`COMTRADE_FILES);
      else if (exp_idx_r != 2'b00) begin
        exp_idx_r    <= exp_idx_r - 2'd1;
        EXPORT_VALID <= 1'b1;
        EXPORT.kind  <= exp_kind;
        EXPORT.start <= rec_start_r;
        EXPORT.length <= rec_len_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes and interrupts
  // ----------------------------------------------------------------
  wire              ev_start  = (st_r == ST_ARMED) & (st_nxt == ST_TRIG);
  wire              ev_full   = enable & trig & ~room & (st_r == ST_ARMED);
  wire              ev_seterr = set_err;
  wire [`IRQ_W-1:0] ev        = {ev_start, ev_full, ev_seterr, rec_done};
  wire [`IRQ_W-1:0] clr       = wr_irq ? AVS_WRITEDATA[`IRQ_W-1:0] : '0;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_r    <= 2'b00;
      pre_ms_r  <= `PRE_DEF_MS;
      post_ms_r <= `POST_DEF_MS;
      max_ms_r  <= `MAX_DEF_MS;
      irq_r     <= '0;
      mask_r    <= '0;
      rec_cnt_r <= 16'h0000;
      used_r    <= 32'h0000_0000;
      rd_addr_r <= '0;
    end else begin
      if (wr_ctrl)  ctrl_r    <= AVS_WRITEDATA[1:0];
      if (wr_pre)   pre_ms_r  <= clamp(AVS_WRITEDATA, `PRE_MIN_MS, `PRE_MAX_MS);
      if (wr_post)  post_ms_r <= clamp(AVS_WRITEDATA, `PRE_MIN_MS, `PRE_MAX_MS);
      if (wr_max)   max_ms_r  <= clamp(AVS_WRITEDATA, `MAX_MIN_MS, `MAX_MAX_MS);
      if (wr_mask)  mask_r    <= AVS_WRITEDATA[`IRQ_W-1:0];
      if (wr_raddr) rd_addr_r <= AVS_WRITEDATA[DEPTH_LOG2-1:0];
      irq_r <= (irq_r & ~clr) | ev;
      if (rec_done) begin
        rec_cnt_r <= rec_cnt_r + 16'd1;
        used_r    <= used_r + rec_bytes;
      end
    end
  end

  assign IRQ     = |(irq_r & mask_r);
  assign WARNING = set_err;

  // ----------------------------------------------------------------
  // Read path: one wait cycle, then data
  // ----------------------------------------------------------------
  logic [31:0] rmux;
  sample_t     rs;
  wire  [31:0] stat_word = {25'h0, trig, set_err, 2'b00, st_r};
  always_comb begin
    rs = mem[rd_addr_r];
    case (AVS_ADDRESS)
      `REG_CTRL_OFF:    rmux = {30'h0, ctrl_r};
      `REG_PRE_OFF:     rmux = {16'h0, pre_ms_r};
      `REG_POST_OFF:    rmux = {16'h0, post_ms_r};
      `REG_MAX_OFF:     rmux = {16'h0, max_ms_r};
      `REG_STAT_OFF:    rmux = stat_word;
      `REG_IRQ_OFF:     rmux = {28'h0, irq_r};
      `REG_MASK_OFF:    rmux = {28'h0, mask_r};
      `REG_REC_OFF:     rmux = {16'h0, rec_cnt_r};
      `REG_RATE_OFF:    rmux = rate_sps;
      `REG_SIZE_OFF:    rmux = used_r;
      `REG_RD_ADDR_OFF: rmux = 32'(rd_addr_r);
      `REG_RD_DATA_OFF: rmux = {rs.bin[15:0], rs.ana[15:0]};
      `REG_CHAN_OFF:    rmux = {16'(`NUM_BIN), 16'(`NUM_ANA)};
      default:          rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_done_r <= 1'b0;
      rd_data_r <= 32'h0000_0000;
    end else begin
      rd_done_r <= rd_req & ~rd_done_r;
      rd_data_r <= rmux;
    end
  end

  assign AVS_WAITREQUEST = rd_req & ~rd_done_r;
  assign AVS_READDATA    = rd_data_r;

endmodule : fault_capture_recorder
`default_nettype wire

// ===== tb/fault_recorder_props.sv
// Port assertions of the fault capture recorder
`timescale 1ns/1ps
`default_nettype none
module fault_recorder_props (
  // Clock and reset
  input wire logic                        CLK,
  input wire logic                        RST_B,
  // Bus and trigger
  input wire logic                        AVS_READ,
  input wire logic                        AVS_WRITE,
  input wire logic                        AVS_WAITREQUEST,
  input wire logic                        TRIGGER,
  // Outputs
  input wire fault_recorder_pkg::export_t EXPORT,
  input wire logic                        EXPORT_VALID,
  input wire logic                        WARNING
);
  import fault_recorder_pkg::*;
  logic wr_seen_r;
  logic trig_seen_r;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_seen_r   <= 1'b0;
      trig_seen_r <= 1'b0;
    end else begin
      wr_seen_r   <= wr_seen_r | AVS_WRITE;
      trig_seen_r <= trig_seen_r | TRIGGER;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  wr_nowait_a: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("write stalled");
  rd_wait_a: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("read answer not in one wait cycle");
  exp_order_a: assert property (EXPORT_VALID && EXPORT.kind == EXP_CFG |=>
    EXPORT_VALID && EXPORT.kind == EXP_DAT ##1 EXPORT_VALID && EXPORT.kind == EXP_INF)
    else $error("export files out of order");
  exp_same_a: assert property (EXPORT_VALID && EXPORT.kind != EXP_CFG |->
    $stable(EXPORT.start) && $stable(EXPORT.length)) else $error("export files differ");
  exp_end_a: assert property (EXPORT_VALID && EXPORT.kind == EXP_INF |=> !EXPORT_VALID)
    else $error("export bundle too long");
  exp_trig_a: assert property (EXPORT_VALID |-> trig_seen_r)
    else $error("record without trigger");
  exp_len_a: assert property (EXPORT_VALID |-> EXPORT.length != 32'h0000_0000)
    else $error("empty record");
  warn_chg_a: assert property ($changed(WARNING) |-> $past(AVS_WRITE))
    else $error("warning moved without write");
  warn_def_a: assert property (!wr_seen_r |-> !WARNING)
    else $error("warning with default settings");
  rd_c: cover property ($rose(AVS_READ));
  exp_c: cover property (EXPORT_VALID && EXPORT.kind == EXP_CFG);
  warn_c: cover property ($rose(WARNING));
endmodule : fault_recorder_props
`default_nettype wire

// ===== tb/front_end_model.sv
// Sampling front end and trigger source model
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        rst_b,
  // Commands
  input wire logic                        slow,
  input wire logic                        trig_cmd,
  input wire fault_recorder_pkg::sample_t sample_data,
  // Recorder side
  output logic                            sample_stb,
  output fault_recorder_pkg::sample_t     sample,
  output logic                            trigger
);
  import fault_recorder_pkg::*;
  logic [2:0] cnt_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r      <= 3'h0;
      sample_stb <= 1'b0;
      sample     <= '0;
      trigger    <= 1'b0;
    end else begin
      cnt_r      <= cnt_r + 3'h1;
      sample_stb <= slow ? (cnt_r == 3'h7) : (cnt_r[1:0] == 2'h3);
      sample     <= (cnt_r[1:0] == 2'h1) ? sample_data : sample;
      trigger    <= trig_cmd;
    end
  end
endmodule : front_end_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking testbench of the fault capture recorder
`timescale 1ns/1ps
`default_nettype none
`include "fault_recorder_consts.svh"
module testbench;
  import fault_recorder_pkg::*;
  localparam int NET = 50;
  logic clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, trig_cmd = 1'b0, slow = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd, seed = 32'h9052_3dab, s2 = 32'h9052_3dab;
  logic avs_waitrequest, sample_stb, trigger, export_valid, warning, irq;
  sample_t sample, sample_data = '0;
  export_t exp_bus;
  int failures = 0, n_checks = 0, n_exp = 0;
  logic [1:0] kinds[$];
  logic [31:0] lens[$];
  logic [31:0] pre_ms = 32'h0000_0000;
  int trig_ticks = 0;
  logic [7:0] ta[6] = '{`REG_PRE_OFF, `REG_PRE_OFF, `REG_POST_OFF, `REG_POST_OFF, `REG_MAX_OFF, `REG_MAX_OFF};
  logic [31:0] tw[6] = '{32'd50, 32'd1500, 32'd99, 32'd1001, 32'd499, 32'd10001};
  logic [31:0] te[6] = '{32'd100, 32'd1000, 32'd100, 32'd1000, 32'd500, 32'd10000};
  always #50 clk = ~clk;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  function automatic logic [31:0] ms_smp(input logic [31:0] ms);
    return 32'(64'(ms) * 64'(`SPP_BASE * NET) / 64'd1000);
  endfunction : ms_smp
  function automatic logic [31:0] exp_len(input logic [31:0] pre, input logic [31:0] post, input logic [31:0] trig_smp);
    return ms_smp(pre) + trig_smp + ms_smp(post);
  endfunction : exp_len
  function automatic logic [31:0] rec_budget(input logic [31:0] ms);
    logic [63:0] b;
    b = 64'((`NUM_ANA * `ANA_KB_PER_S + `NUM_BIN * `BIN_KB_PER_S) * `KB_BYTES) * 64'(ms);
    return 32'(b / 64'd1000);
  endfunction : rec_budget
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    rd = avs_readdata;
    if (i >= 20) begin
      failures++;
      close_out();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wait_exp(input int n, input int bound);
    for (int i = 0; i < bound && n_exp < n; i++) @(posedge clk);
    if (n_exp < n) begin
      failures++;
      close_out();
    end
  endtask : wait_exp
  // ----------------------------------------------------------------
  // Design, front end and monitors
  // ----------------------------------------------------------------
  fault_capture_recorder #(.SELECTABLE(1), .DEPTH_LOG2(12), .NET_HZ(NET)) fault_capture_recorder_inst (
    .CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .SAMPLE_STB(sample_stb), .SAMPLE(sample), .TRIGGER(trigger), .EXPORT(exp_bus),
    .EXPORT_VALID(export_valid), .WARNING(warning), .IRQ(irq));
  front_end_model front_end_model_inst (.clk(clk), .rst_b(rst_b), .slow(slow), .trig_cmd(trig_cmd),
    .sample_data(sample_data), .sample_stb(sample_stb), .sample(sample), .trigger(trigger));
  always @(posedge clk) begin
    seed = xorshift(seed);
    sample_data <= {18{seed}};
    if (export_valid === 1'b1) begin
      kinds.push_back(exp_bus.kind);
      lens.push_back(exp_bus.length);
      n_exp++;
    end
  end
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk_bit(warning, 1'b0);
    chk_bit(irq, 1'b0);
    bus(1'b0, `REG_PRE_OFF, 32'h0);
    chk_word(rd, 32'd200);
    bus(1'b0, `REG_POST_OFF, 32'h0);
    chk_word(rd, 32'd200);
    bus(1'b0, `REG_MAX_OFF, 32'h0);
    chk_word(rd, 32'd1000);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, ta[i], tw[i]);
      bus(1'b0, ta[i], 32'h0);
      chk_word(rd, te[i]);
    end
    s2 = xorshift(s2);
    bus(1'b1, `REG_PRE_OFF, 32'd1000);
    bus(1'b1, `REG_POST_OFF, 32'd1000);
    bus(1'b1, `REG_MAX_OFF, 32'd1999);
    chk_bit(warning, 1'b1);
    bus(1'b1, `REG_MAX_OFF, 32'd2000);
    chk_bit(warning, 1'b0);
    pre_ms = 32'd100 + {22'h0, s2[9:0] % 10'd50};
    trig_ticks = 20 + int'(s2[15:10]);
    bus(1'b1, `REG_PRE_OFF, pre_ms);
    bus(1'b1, `REG_POST_OFF, 32'd100);
    bus(1'b1, `REG_MAX_OFF, 32'd500);
    bus(1'b1, `REG_CTRL_OFF, 32'h0000_0002);
    bus(1'b0, `REG_RATE_OFF, 32'h0);
    chk_word(rd, 32'd2000);
    bus(1'b1, `REG_CTRL_OFF, 32'h0000_0000);
    bus(1'b0, `REG_RATE_OFF, 32'h0);
    chk_word(rd, 32'd1000);
    bus(1'b0, 8'hFC, 32'h0);
    chk_word(rd, 32'h0000_0000);
    trig_cmd <= 1'b1;
    repeat (800) @(posedge clk);
    chk_word(32'(n_exp), 32'd0);
    trig_cmd <= 1'b0;
    bus(1'b1, `REG_MASK_OFF, 32'h0000_0001);
    bus(1'b1, `REG_CTRL_OFF, 32'h0000_0001);
    repeat (800) @(posedge clk);
    trig_cmd <= 1'b1;
    repeat (4 * trig_ticks) @(posedge clk);
    trig_cmd <= 1'b0;
    wait_exp(3, 2000);
    for (int i = 0; i < 3; i++) chk_word({30'h0, kinds[i]}, 32'(i));
    chk_bit(lens[0] + 32'd2 >= exp_len(pre_ms, 32'd100, 32'(trig_ticks)) &&
            lens[0] <= exp_len(pre_ms, 32'd100, 32'(trig_ticks)) + 32'd2, 1'b1);
    chk_bit(irq, 1'b1);
    bus(1'b0, `REG_IRQ_OFF, 32'h0);
    chk_word(rd & 32'h0000_0001, 32'h0000_0001);
    bus(1'b1, `REG_IRQ_OFF, 32'h0000_000F);
    chk_bit(irq, 1'b0);
    slow <= 1'b1;
    repeat (1200) @(posedge clk);
    trig_cmd <= 1'b1;
    wait_exp(6, 8000);
    repeat (3000) @(posedge clk);
    chk_word(32'(n_exp), 32'd6);
    chk_word(lens[3], exp_len(pre_ms, 32'd100, ms_smp(32'd500)));
    bus(1'b0, `REG_SIZE_OFF, 32'h0);
    chk_word(rd, 32'd2 * rec_budget(32'd500 + pre_ms + 32'd100));
    bus(1'b0, `REG_CHAN_OFF, 32'h0);
    chk_word(rd, {16'(`NUM_BIN), 16'(`NUM_ANA)});
    trig_cmd <= 1'b0;
    bus(1'b0, `REG_REC_OFF, 32'h0);
    chk_word(rd, 32'd2);
    close_out();
  end
endmodule : testbench
bind fault_capture_recorder fault_recorder_props fault_recorder_props_inst (.CLK(CLK), .RST_B(RST_B),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TRIGGER(TRIGGER),
  .EXPORT(EXPORT), .EXPORT_VALID(EXPORT_VALID), .WARNING(WARNING));
`default_nettype wire
